// [exec_pkg.sv]
// shared constants and types for the instruction subset execution unit
// assumes a single core clock; all users import the whole package
`default_nettype none

package exec_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int FILE_ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   localparam int FILE_DEPTH = 128;

   // ----------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic GIE_RESET = 1'b0;
   localparam logic TARGET_ACC = 1'b0;
   localparam logic TARGET_FILE = 1'b1;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [12:0] PC_STEP = 13'h0001;

   // ----------------------------------------------------------------
   // operations and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      nop_op,
      increment_file_op,
      or_w_file_op,
      copy_file_op,
      load_literal_op,
      store_w_op,
      interrupt_return_op,
      literal_return_op,
      rotate_left_carry_op
   } op_type;

   typedef enum logic {
      run_state,
      flush_state
   } exec_state_type;

endpackage

`default_nettype wire

// [file_port_if.sv]
// port between the execution core and the file-register store
// assumes read is combinational and write lands on the clock edge
`default_nettype none

interface file_port_if;
   import exec_pkg::*;
   logic [FILE_ADDR_W-1:0] raddr;
   logic [DATA_W-1:0] rdata;
   logic we;
   logic [FILE_ADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;

   modport core (output raddr, output we, output waddr, output wdata, input rdata);
   modport store (input raddr, input we, input waddr, input wdata, output rdata);
endinterface

`default_nettype wire

// [file_reg_store.sv]
// file-register space of 128 bytes
// assumes write enable and address come from logic on the same clock
`default_nettype none

module file_reg_store
   import exec_pkg::*;
#(
   parameter int DEPTH = FILE_DEPTH
) (
   // clock
   input wire logic clk_i,
   // core side
   file_port_if.store port
);

   logic [DATA_W-1:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (port.we) begin
         mem[port.waddr] <= port.wdata;
      end
   end

   assign port.rdata = mem[port.raddr];

endmodule // file_reg_store

`default_nettype wire

// [mcu_instruction_subset_exec.sv]
// execution unit for a subset of an 8-bit controller instruction set
// assumes decoded operations arrive on the core clock with their operands
//
// How it works
// - file operand is a 7-bit address 0..127; destination is one bit
// - destination bit 0 writes accumulator, 1 writes the file register back
// - increment adds one to the file register, zero flag follows result
// - OR of accumulator and file register to destination, zero flag updated
// - copy passes file register to destination and updates zero flag
// - load literal puts 8-bit immediate in accumulator, flags untouched
// - store copies accumulator into file register, flags untouched
// - interrupt return pops stack into program counter and sets irq enable
// - literal return loads immediate into accumulator, pops stack into pc
// - literal return takes two instruction cycles
// - rotate left through carry: old carry to bit 0, bit 7 to carry
`default_nettype none

module mcu_instruction_subset_exec
   import exec_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // instruction
   input wire logic instr_valid_i,
   input wire op_type op_i,
   input wire logic [FILE_ADDR_W-1:0] file_addr_i,
   input wire logic target_i,
   input wire logic [DATA_W-1:0] literal_i,
   // return stack and interrupt entry
   input wire logic [PC_W-1:0] stack_top_i,
   input wire logic irq_accept_i,
   // status
   output logic ready_o,
   output logic retire_o,
   output logic stack_pop_o,
   output logic [PC_W-1:0] pc_o,
   output logic [DATA_W-1:0] acc_o,
   output logic null_result_flag_o,
   output logic carry_flag_o,
   output logic global_irq_enable_o
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_sync1_r;
   logic rst_sync2_r;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   assign rst_n = rst_sync2_r;

   // ----------------------------------------------------------------
   // file-register store
   // ----------------------------------------------------------------
   file_port_if fport ();

   file_reg_store #(
      .DEPTH(FILE_DEPTH)
   ) u_store (
      .clk_i(mclk_i),
      .port(fport.store)
   );

   // ----------------------------------------------------------------
   // operand fetch and result
   // ----------------------------------------------------------------
   exec_state_type state_r;
   logic take;
   logic [DATA_W-1:0] fdata;
   logic [DATA_W-1:0] result_nxt;
   logic dest_op;
   logic is_return;

   // ready_o low in reset, first cycle after it and the flush cycle: no file write then
   assign take = instr_valid_i && ready_o && (state_r == run_state);
   assign fdata = fport.rdata;
   assign is_return = (op_i == interrupt_return_op) || (op_i == literal_return_op);

   always_comb begin
      result_nxt = ZERO_BYTE;
      dest_op = 1'b0;
      unique case (op_i)
         increment_file_op: begin
            result_nxt = fdata + ONE_BYTE;
            dest_op = 1'b1;
         end
         or_w_file_op: begin
            result_nxt = acc_o | fdata;
            dest_op = 1'b1;
         end
         copy_file_op: begin
            result_nxt = fdata;
            dest_op = 1'b1;
         end
         rotate_left_carry_op: begin
            result_nxt = {fdata[DATA_W-2:0], carry_flag_o};
            dest_op = 1'b1;
         end
         nop_op, load_literal_op, store_w_op, interrupt_return_op, literal_return_op: begin
            result_nxt = ZERO_BYTE;
         end
         default: begin
            result_nxt = ZERO_BYTE;
         end
      endcase
   end

   assign fport.raddr = file_addr_i;
   assign fport.waddr = file_addr_i;
   assign fport.we = take && ((dest_op && target_i == TARGET_FILE) || op_i == store_w_op);
   assign fport.wdata = (op_i == store_w_op) ? acc_o : result_nxt;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= run_state;
         ready_o <= 1'b0;
         retire_o <= 1'b0;
      end else begin
         unique case (state_r)
            run_state: begin
               ready_o <= 1'b1;
               retire_o <= 1'b0;
               if (take && op_i == literal_return_op) begin
                  state_r <= flush_state;
                  ready_o <= 1'b0;
               end else if (take) begin
                  retire_o <= 1'b1;
               end
            end
            flush_state: begin
               state_r <= run_state;
               ready_o <= 1'b1;
               retire_o <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // accumulator
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_o <= ACC_RESET;
      end else if (take) begin
         if (op_i == load_literal_op || op_i == literal_return_op) begin
            acc_o <= literal_i;
         end else if (dest_op && target_i == TARGET_ACC) begin
            acc_o <= result_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         null_result_flag_o <= FLAG_RESET;
      end else if (take && (op_i == increment_file_op || op_i == or_w_file_op || op_i == copy_file_op)) begin
         null_result_flag_o <= (result_nxt == ZERO_BYTE);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         carry_flag_o <= FLAG_RESET;
      end else if (take && op_i == rotate_left_carry_op) begin
         carry_flag_o <= fdata[DATA_W-1];
      end
   end

   // set beats interrupt entry clearing in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable_o <= GIE_RESET;
      end else if (take && op_i == interrupt_return_op) begin
         global_irq_enable_o <= 1'b1;
      end else if (irq_accept_i) begin
         global_irq_enable_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // program counter and stack pop
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pc_o <= PC_RESET;
         stack_pop_o <= 1'b0;
      end else begin
         stack_pop_o <= take && is_return;
         if (take && is_return) begin
            pc_o <= stack_top_i;
         end else if (take) begin
            pc_o <= pc_o + PC_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n);

   a_incr_to_acc: assert property (take && op_i == increment_file_op && target_i == TARGET_ACC
      |=> acc_o == DATA_W'($past(fdata) + ONE_BYTE) && null_result_flag_o == (acc_o == ZERO_BYTE))
      else $error("increment result wrong");
   a_or_to_acc: assert property (take && op_i == or_w_file_op && target_i == TARGET_ACC
      |=> acc_o == ($past(acc_o) | $past(fdata)))
      else $error("or result wrong");
   a_copy_zero_flag: assert property (take && op_i == copy_file_op
      |=> null_result_flag_o == ($past(fdata) == ZERO_BYTE) && pc_o == PC_W'($past(pc_o) + PC_STEP))
      else $error("copy zero flag wrong");
   a_literal_no_flags: assert property (take && op_i == load_literal_op
      |=> acc_o == $past(literal_i) && $stable(null_result_flag_o) && $stable(carry_flag_o))
      else $error("literal load wrong");
   a_store_keeps_state: assert property (take && op_i == store_w_op
      |-> fport.we && fport.wdata == acc_o ##1 $stable(acc_o) && $stable(null_result_flag_o))
      else $error("store wrong");
   a_irq_return_pc: assert property (take && op_i == interrupt_return_op
      |=> global_irq_enable_o && stack_pop_o && pc_o == $past(stack_top_i) && $stable(null_result_flag_o))
      else $error("interrupt return wrong");
   a_literal_return_pc: assert property (take && op_i == literal_return_op
      |=> acc_o == $past(literal_i) && pc_o == $past(stack_top_i) && stack_pop_o)
      else $error("literal return wrong");
   a_literal_two_cycles: assert property (take && op_i == literal_return_op
      |=> !ready_o && !retire_o ##1 ready_o && retire_o && !stack_pop_o)
      else $error("literal return not two cycles");
   a_rotate_carry: assert property (take && op_i == rotate_left_carry_op && target_i == TARGET_ACC
      |=> carry_flag_o == $past(fdata[DATA_W-1]) && acc_o == {$past(fdata[DATA_W-2:0]), $past(carry_flag_o)})
      else $error("rotate wrong");
   a_nop_only_pc: assert property (take && op_i == nop_op
      |-> !fport.we ##1 retire_o && $stable(acc_o) && $stable(carry_flag_o) && pc_o == PC_W'($past(pc_o) + PC_STEP))
      else $error("nop changed state");

endmodule // mcu_instruction_subset_exec

`default_nettype wire

// [test_mcu_instruction_subset_exec.sv]
// self-checking bench for the instruction subset execution unit
// assumes the unit's internal file store and the exec_pkg encodings
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module test_mcu_instruction_subset_exec;
   timeunit 1ns;
   timeprecision 100ps;
   import exec_pkg::*;

   logic mclk_i;
   logic resetn_i;
   logic instr_valid_i;
   op_type op_i;
   logic [FILE_ADDR_W-1:0] file_addr_i;
   logic target_i;
   logic [DATA_W-1:0] literal_i;
   logic [PC_W-1:0] stack_top_i;
   logic irq_accept_i;
   logic ready_o;
   logic retire_o;
   logic stack_pop_o;
   logic [PC_W-1:0] pc_o;
   logic [DATA_W-1:0] acc_o;
   logic null_result_flag_o;
   logic carry_flag_o;
   logic global_irq_enable_o;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [PC_W-1:0] pc_exp = 13'h0000;

   mcu_instruction_subset_exec u_mcu_instruction_subset_exec (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i), .op_i(op_i),
      .file_addr_i(file_addr_i), .target_i(target_i), .literal_i(literal_i), .stack_top_i(stack_top_i),
      .irq_accept_i(irq_accept_i), .ready_o(ready_o), .retire_o(retire_o), .stack_pop_o(stack_pop_o),
      .pc_o(pc_o), .acc_o(acc_o), .null_result_flag_o(null_result_flag_o), .carry_flag_o(carry_flag_o),
      .global_irq_enable_o(global_irq_enable_o));

   // ----------------------------------------------------------------
   // clock and timeout
   // ----------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one instruction, taken at the rising edge, judged in the cycle after
   task automatic issue(input op_type op, input logic [FILE_ADDR_W-1:0] a, input logic t,
                        input logic [DATA_W-1:0] k);
      logic ret;
      @(negedge mclk_i);
      op_i = op;
      file_addr_i = a;
      target_i = t;
      literal_i = k;
      instr_valid_i = 1'b1;
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
      ret = (op == interrupt_return_op);
      pc_exp = ret ? stack_top_i : pc_exp + PC_STEP;
      `CHK(pc_o, pc_exp)
      `CHK(stack_pop_o, ret)
      `CHK(retire_o, 1'b1)
   endtask

   task automatic expect_state(input logic [DATA_W-1:0] acc, input logic z, input logic c);
      `CHK(acc_o, acc)
      `CHK(null_result_flag_o, z)
      `CHK(carry_flag_o, c)
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_move();
      issue(load_literal_op, 7'h00, 1'b0, 8'h00);
      issue(store_w_op, 7'h00, 1'b1, 8'h00);
      issue(load_literal_op, 7'h00, 1'b0, 8'h5a);
      issue(copy_file_op, 7'h00, TARGET_FILE, 8'h00);
      expect_state(8'h5a, 1'b1, 1'b0);
      issue(load_literal_op, 7'h00, 1'b0, 8'hff);
      expect_state(8'hff, 1'b1, 1'b0);
      issue(store_w_op, 7'h7f, 1'b0, 8'h00);
      expect_state(8'hff, 1'b1, 1'b0);
      issue(load_literal_op, 7'h00, 1'b0, 8'h00);
      issue(copy_file_op, 7'h7f, TARGET_ACC, 8'h00);
      expect_state(8'hff, 1'b0, 1'b0);
   endtask

   task automatic t_incr();
      issue(increment_file_op, 7'h7f, TARGET_ACC, 8'h00);
      expect_state(8'h00, 1'b1, 1'b0);
      issue(load_literal_op, 7'h00, 1'b0, 8'h77);
      issue(increment_file_op, 7'h7f, TARGET_FILE, 8'h00);
      expect_state(8'h77, 1'b1, 1'b0);
      issue(increment_file_op, 7'h7f, TARGET_FILE, 8'h00);
      issue(copy_file_op, 7'h7f, TARGET_ACC, 8'h00);
      expect_state(8'h01, 1'b0, 1'b0);
   endtask

   task automatic t_or();
      issue(load_literal_op, 7'h00, 1'b0, 8'h50);
      issue(store_w_op, 7'h03, 1'b0, 8'h00);
      issue(load_literal_op, 7'h00, 1'b0, 8'h0a);
      issue(or_w_file_op, 7'h03, TARGET_FILE, 8'h00);
      expect_state(8'h0a, 1'b0, 1'b0);
      issue(copy_file_op, 7'h03, TARGET_ACC, 8'h00);
      expect_state(8'h5a, 1'b0, 1'b0);
      issue(load_literal_op, 7'h00, 1'b0, 8'h00);
      issue(store_w_op, 7'h04, 1'b0, 8'h00);
      issue(or_w_file_op, 7'h04, TARGET_ACC, 8'h00);
      expect_state(8'h00, 1'b1, 1'b0);
   endtask

   task automatic t_rotate();
      issue(load_literal_op, 7'h00, 1'b0, 8'h81);
      issue(store_w_op, 7'h09, 1'b0, 8'h00);
      issue(rotate_left_carry_op, 7'h09, TARGET_ACC, 8'h00);
      expect_state(8'h02, 1'b1, 1'b1);
      issue(rotate_left_carry_op, 7'h09, TARGET_FILE, 8'h00);
      issue(copy_file_op, 7'h09, TARGET_ACC, 8'h00);
      expect_state(8'h03, 1'b0, 1'b1);
   endtask

   // second cycle of the return refuses a new instruction
   task automatic t_lit_return();
      @(negedge mclk_i);
      stack_top_i = 13'h0123;
      op_i = literal_return_op;
      literal_i = 8'h3c;
      instr_valid_i = 1'b1;
      @(negedge mclk_i);
      op_i = load_literal_op;
      literal_i = 8'h11;
      expect_state(8'h3c, 1'b0, 1'b1);
      `CHK(pc_o, 13'h0123)
      `CHK(stack_pop_o, 1'b1)
      `CHK(ready_o, 1'b0)
      `CHK(retire_o, 1'b0)
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
      `CHK(retire_o, 1'b1)
      `CHK(acc_o, 8'h3c)
      `CHK(pc_o, 13'h0123)
      pc_exp = 13'h0123;
   endtask

   task automatic t_irq_return();
      @(negedge mclk_i);
      irq_accept_i = 1'b1;
      @(negedge mclk_i);
      `CHK(global_irq_enable_o, 1'b0)
      irq_accept_i = 1'b0;
      stack_top_i = 13'h1456;
      issue(interrupt_return_op, 7'h00, 1'b0, 8'h00);
      `CHK(global_irq_enable_o, 1'b1)
      expect_state(8'h3c, 1'b0, 1'b1);
      irq_accept_i = 1'b1;
      stack_top_i = 13'h0042;
      @(negedge mclk_i);
      `CHK(global_irq_enable_o, 1'b0)
      issue(interrupt_return_op, 7'h00, 1'b0, 8'h00);
      irq_accept_i = 1'b0;
      `CHK(global_irq_enable_o, 1'b1)
   endtask

   task automatic t_nop();
      issue(nop_op, 7'h7f, 1'b1, 8'hff);
      expect_state(8'h3c, 1'b0, 1'b1);
      `CHK(global_irq_enable_o, 1'b1)
      issue(copy_file_op, 7'h7f, TARGET_ACC, 8'h00);
      expect_state(8'h01, 1'b0, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn_i = 1'b0;
      instr_valid_i = 1'b0;
      op_i = nop_op;
      file_addr_i = 7'h00;
      target_i = 1'b0;
      literal_i = 8'h00;
      stack_top_i = 13'h0000;
      irq_accept_i = 1'b0;
      repeat (20) @(negedge mclk_i);
      resetn_i = 1'b1;
      for (int i = 0; i < 10 && ready_o !== 1'b1; i++)
         @(negedge mclk_i);
      t_move();
      t_incr();
      t_or();
      t_rotate();
      t_lit_return();
      t_irq_return();
      t_nop();
      wrap_up();
   end
endmodule // test_mcu_instruction_subset_exec

`default_nettype wire
